//--- logic/t8w_pkg.sv
// Contract
// R1 - clear-on-compare: match clears count to zero
// R2 - clear-on-compare: match flag set at top
// R3 - clear-on-compare: compare writes unbuffered, may wrap
// R4 - clear-on-compare: output mode 1 toggles
// R5 - pin shows waveform only when direction out
// R6 - clear-on-compare: overflow on max to zero
// R7 - fast pwm counts bottom to max, restarts
// R8 - fast pwm: mode2 clear/set, mode3 set/clear
// R9 - fast pwm: max one tick, bottom action
// R10 - fast pwm: overflow flag at max
// R11 - pwm modes: compare value double buffered
// R12 - fast pwm extremes: spike or constant level
// R13 - fast pwm output mode 1 toggles
// R14 - phase correct counts up then down
// R15 - phase correct: max one tick, reverse
// R16 - phase correct: up/down match actions
// R17 - phase correct: overflow at bottom
// R18 - phase correct extremes give constant levels
// R19 - phase correct: top level equals up-match result
// R20 - phase correct: missed up-match fixed at top
// R21 - buffer loads at top or bottom
// R22 - match flag one tick later, write-one clears
// R23 - count write blocks next tick's match
// R24 - fast pwm: match at top ignored
// R25 - everything advances only on timer tick
package t8w_pkg;
  // =====================================================
  // widths and extreme counts
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // =====================================================
  // waveform mode selector values
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR_CMP = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;
  // =====================================================
  // compare output mode values
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // =====================================================
  // reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic RST_WAVE = 1'b0;
  // =====================================================
  // counting direction for the dual-slope mode
  typedef enum logic {DIR_UP, DIR_DOWN} t8w_dir_type;
endpackage

//--- logic/t8w_wavegen.sv
`timescale 1ns/1ps
module t8w_wavegen (
  // clock, reset and tick step
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_step,
  // configuration
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_com,
  // events from the counter and the force strobe
  input wire logic i_match,
  input wire logic i_force,
  input wire logic i_at_top,
  input wire logic i_up,
  input wire logic i_cmp_is_max,
  // waveform level
  output logic o_wave
);
  // =====================================================
  // waveform register
  logic wave_reg;
  logic wave_next;
  logic lvl_match;

  // next waveform level, actions resolved by mode
  always_comb begin
    wave_next = wave_reg;
    lvl_match = (i_com == t8w_pkg::COM_SET);
    case (i_mode)
      t8w_pkg::MODE_NORMAL, t8w_pkg::MODE_CLEAR_CMP: begin
        // force acts like a match but never touches flag or count
        if (i_force || (i_step && i_match)) begin
          if (i_com == t8w_pkg::COM_TOGGLE) begin
            wave_next = ~wave_reg; // see R4
          end else if (i_com != t8w_pkg::COM_OFF) begin
            wave_next = lvl_match;
          end
        end
      end
      t8w_pkg::MODE_FAST: begin
        if (i_step) begin
          if (i_com == t8w_pkg::COM_TOGGLE) begin
            if (i_match) begin
              wave_next = ~wave_reg; // see R13
            end
          end else if (i_com != t8w_pkg::COM_OFF) begin
            if (i_at_top) begin
              wave_next = ~lvl_match; // see R8 see R9
            end else if (i_match && !i_cmp_is_max) begin
              wave_next = lvl_match; // see R8 see R12 see R24
            end
          end
        end
      end
      t8w_pkg::MODE_PHASE: begin
        if (i_step && i_com[1]) begin
          if (i_at_top) begin
            // compare at max keeps the down-match level, else force the
            // up-match level so a missed or skipped match stays symmetric
            wave_next = i_cmp_is_max ? ~lvl_match : lvl_match; // see R19 see R20 see R18
          end else if (i_match) begin
            wave_next = i_up ? lvl_match : ~lvl_match; // see R16
          end
        end
      end
      default: wave_next = wave_reg;
    endcase
  end

  // register only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wave_reg <= t8w_pkg::RST_WAVE;
    end else begin
      wave_reg <= wave_next;
    end
  end

  assign o_wave = wave_reg;
endmodule

//--- logic/t8w_timer.sv
`timescale 1ns/1ps
module t8w_timer (
  // clock, reset, enables
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_tick,
  // configuration
  input wire logic [1:0] i_waveform_mode_sel,
  input wire logic [1:0] i_compare_output_mode,
  input wire logic i_force,
  // software writes
  input wire logic i_cnt_wr,
  input wire logic [7:0] i_cnt_wdata,
  input wire logic i_cmp_wr,
  input wire logic [7:0] i_cmp_wdata,
  // flag clears, write-one or interrupt service
  input wire logic i_cmf_clr,
  input wire logic i_ovf_clr,
  // port pin control
  input wire logic i_dir_out,
  input wire logic i_port_val,
  // status
  output logic [7:0] o_timer_count,
  output logic [7:0] o_compare_value,
  output logic [7:0] o_compare_buffer,
  output logic o_compare_match_flag,
  output logic o_overflow_flag,
  output logic o_wave_output,
  // pin drive
  output logic o_pin_out,
  output logic o_pin_oe_n
);
  // =====================================================
  // helpers
  function automatic logic is_pwm(input logic [1:0] mode);
    is_pwm = (mode == t8w_pkg::MODE_PHASE) || (mode == t8w_pkg::MODE_FAST);
  endfunction

  // =====================================================
  // state
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] cmp_act_reg;
  logic [7:0] cmp_act_next;
  logic [7:0] cmp_buf_reg;
  logic [7:0] cmp_buf_next;
  t8w_pkg::t8w_dir_type dir_reg;
  t8w_pkg::t8w_dir_type dir_next;
  logic blk_reg;
  logic blk_next;
  logic pend_reg;
  logic pend_next;
  logic cmf_reg;
  logic cmf_next;
  logic ovf_reg;
  logic ovf_next;
  logic pin_reg;
  logic pin_next;
  logic oe_n_reg;
  logic oe_n_next;

  logic step;
  logic match_now;
  logic at_max;
  logic at_bottom;
  logic wave;
  logic counting_up;

  // a tick only counts while the clock enable holds
  assign step = i_ce && i_tick; // see R25
  assign at_max = (cnt_reg == t8w_pkg::CNT_MAX);
  assign at_bottom = (cnt_reg == t8w_pkg::CNT_BOTTOM);
  // a fresh count write masks the comparator until the next tick
  assign match_now = (cnt_reg == cmp_act_reg) && !blk_reg; // see R23
  // bottom counts as up so a zero compare gives a steady level
  assign counting_up = (dir_reg == t8w_pkg::DIR_UP) || at_bottom;

  // =====================================================
  // counter, direction and match blocking
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    blk_next = blk_reg;
    if (step) begin
      blk_next = 1'b0;
      case (i_waveform_mode_sel)
        t8w_pkg::MODE_CLEAR_CMP: begin
          // compare below count is missed until the count wraps
          cnt_next = match_now ? t8w_pkg::CNT_BOTTOM : cnt_reg + t8w_pkg::CNT_ONE; // see R1 see R3
        end
        t8w_pkg::MODE_FAST: begin
          cnt_next = cnt_reg + t8w_pkg::CNT_ONE; // see R7 see R9
        end
        t8w_pkg::MODE_PHASE: begin
          if (at_max) begin
            dir_next = t8w_pkg::DIR_DOWN; // see R15
          end else if (at_bottom) begin
            dir_next = t8w_pkg::DIR_UP; // see R14
          end
          if (at_max || (dir_reg == t8w_pkg::DIR_DOWN && !at_bottom)) begin
            cnt_next = cnt_reg - t8w_pkg::CNT_ONE; // see R14
          end else begin
            cnt_next = cnt_reg + t8w_pkg::CNT_ONE;
          end
        end
        default: cnt_next = cnt_reg + t8w_pkg::CNT_ONE;
      endcase
    end
    // software write wins over counting and blocks the next tick's match
    if (i_ce && i_cnt_wr) begin
      cnt_next = i_cnt_wdata;
      blk_next = 1'b1; // see R23
    end
    if (i_waveform_mode_sel != t8w_pkg::MODE_PHASE) begin
      dir_next = t8w_pkg::DIR_UP;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= t8w_pkg::RST_COUNT;
      dir_reg <= t8w_pkg::DIR_UP;
      blk_reg <= 1'b0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      blk_reg <= blk_next;
    end
  end

  // =====================================================
  // compare value and its buffer
  always_comb begin
    cmp_buf_next = cmp_buf_reg;
    cmp_act_next = cmp_act_reg;
    if (i_cmp_wr) begin
      cmp_buf_next = i_cmp_wdata; // see R11
    end
    if (!is_pwm(i_waveform_mode_sel)) begin
      // no buffering outside the pwm modes
      if (i_cmp_wr) begin
        cmp_act_next = i_cmp_wdata; // see R3
      end
    end else if (step && at_max) begin
      // fast pwm loads as the count leaves max for bottom, dual-slope at top
      cmp_act_next = cmp_buf_reg; // see R21
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cmp_act_reg <= t8w_pkg::RST_COMPARE;
      cmp_buf_reg <= t8w_pkg::RST_COMPARE;
    end else if (i_ce) begin
      cmp_act_reg <= cmp_act_next;
      cmp_buf_reg <= cmp_buf_next;
    end
  end

  // =====================================================
  // flags: a set in the same cycle as a clear wins
  always_comb begin
    pend_next = pend_reg;
    cmf_next = cmf_reg;
    ovf_next = ovf_reg;
    if (i_cmf_clr) begin
      cmf_next = 1'b0;
    end
    if (i_ovf_clr) begin
      ovf_next = 1'b0;
    end
    if (step) begin
      // match seen on this tick raises the flag on the next tick
      pend_next = match_now;
      if (pend_reg) begin
        cmf_next = 1'b1; // see R2 see R22
      end
      if (i_waveform_mode_sel == t8w_pkg::MODE_PHASE) begin
        if (at_bottom && dir_reg == t8w_pkg::DIR_DOWN) begin
          ovf_next = 1'b1; // see R17
        end
      end else if (at_max && !(match_now && i_waveform_mode_sel == t8w_pkg::MODE_CLEAR_CMP)) begin
        ovf_next = 1'b1; // see R6 see R10
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pend_reg <= 1'b0;
      cmf_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (i_ce) begin
      pend_reg <= pend_next;
      cmf_reg <= cmf_next;
      ovf_reg <= ovf_next;
    end
  end

  // =====================================================
  // waveform generator
  t8w_wavegen u_wave (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_step(step),
    .i_mode(i_waveform_mode_sel),
    .i_com(i_compare_output_mode),
    .i_match(match_now),
    .i_force(i_ce && i_force),
    .i_at_top(at_max),
    .i_up(counting_up),
    .i_cmp_is_max(cmp_act_reg == t8w_pkg::CNT_MAX),
    .o_wave(wave)
  );

  // =====================================================
  // pin override; registered so the pin never glitches on decode
  always_comb begin
    pin_next = 1'b0;
    oe_n_next = !i_dir_out; // see R5
    if (i_dir_out) begin
      pin_next = (i_compare_output_mode != t8w_pkg::COM_OFF) ? wave : i_port_val; // see R5
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (i_ce) begin
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign o_timer_count = cnt_reg;
  assign o_compare_value = cmp_act_reg;
  assign o_compare_buffer = cmp_buf_reg;
  assign o_compare_match_flag = cmf_reg;
  assign o_overflow_flag = ovf_reg;
  assign o_wave_output = wave;
  assign o_pin_out = pin_reg;
  assign o_pin_oe_n = oe_n_reg;

  // =====================================================
  // checks
  AST_CTC_CLEAR: assert property ( // see R1
    @(posedge i_clk) disable iff (i_srst)
    (step && match_now && !i_cnt_wr && i_waveform_mode_sel == t8w_pkg::MODE_CLEAR_CMP)
    |=> (cnt_reg == t8w_pkg::CNT_BOTTOM))
    else $error("count not cleared on compare match");

  // the match is held in pend_reg until the next tick, however far off it is
  AST_CMF_ARMED: assert property ( // see R22
    @(posedge i_clk) disable iff (i_srst)
    (step && match_now) |=> pend_reg)
    else $error("match on a tick not remembered for the flag");

  AST_CMF_NEXT_TICK: assert property ( // see R22
    @(posedge i_clk) disable iff (i_srst)
    (step && pend_reg) |=> cmf_reg)
    else $error("match flag not set one tick after match");

  AST_CTC_OVF: assert property ( // see R6
    @(posedge i_clk) disable iff (i_srst)
    (step && at_max && !match_now && i_waveform_mode_sel == t8w_pkg::MODE_CLEAR_CMP)
    |=> ovf_reg)
    else $error("overflow flag missing at wrap");

  AST_FAST_WRAP: assert property ( // see R9
    @(posedge i_clk) disable iff (i_srst)
    (step && at_max && !i_cnt_wr && i_waveform_mode_sel == t8w_pkg::MODE_FAST)
    |=> (cnt_reg == t8w_pkg::CNT_BOTTOM) && ovf_reg)
    else $error("fast pwm did not wrap from max");

  AST_PC_TURN: assert property ( // see R15
    @(posedge i_clk) disable iff (i_srst)
    (step && at_max && !i_cnt_wr && i_waveform_mode_sel == t8w_pkg::MODE_PHASE)
    |=> (dir_reg == t8w_pkg::DIR_DOWN) && (cnt_reg == (t8w_pkg::CNT_MAX - t8w_pkg::CNT_ONE)))
    else $error("dual-slope count did not turn at max");

  AST_PC_OVF: assert property ( // see R17
    @(posedge i_clk) disable iff (i_srst)
    (step && at_bottom && dir_reg == t8w_pkg::DIR_DOWN
      && i_waveform_mode_sel == t8w_pkg::MODE_PHASE)
    |=> ovf_reg)
    else $error("overflow flag missing at bottom");

  AST_PIN_HIDDEN: assert property ( // see R5
    @(posedge i_clk) disable iff (i_srst)
    (i_ce && !i_dir_out) |=> (o_pin_oe_n && !o_pin_out))
    else $error("pin driven while direction is input");

  AST_WRITE_BLOCKS: assert property ( // see R23
    @(posedge i_clk) disable iff (i_srst)
    (i_ce && i_cnt_wr) |=> !match_now)
    else $error("match not blocked after count write");

  AST_PWM_BUFFERED: assert property ( // see R11
    @(posedge i_clk) disable iff (i_srst)
    (i_ce && i_cmp_wr && !(step && at_max) && is_pwm(i_waveform_mode_sel))
    |=> $stable(cmp_act_reg))
    else $error("pwm compare value changed outside update point");

  AST_FROZEN: assert property ( // see R25
    @(posedge i_clk) disable iff (i_srst)
    !i_ce |=> $stable(cnt_reg) && $stable(cmf_reg) && $stable(o_wave_output))
    else $error("state moved while clock enable low");
endmodule

//--- tb/t8w_pin_load.sv
`timescale 1ns/1ps
module t8w_pin_load (
  // driver side of the pad
  input wire logic i_pin_out,
  input wire logic i_pin_oe_n,
  // level seen by the load
  output logic o_level
);
  // =====================================================
  // pad with pull-up
  // a pull-up makes a released pin read high, so a low wave level stays hidden
  assign o_level = i_pin_oe_n ? 1'h1 : i_pin_out;
endmodule

//--- tb/tb_t8w_timer.sv
`timescale 1ns/1ps
module tb_t8w_timer;
  // =====================================================
  // stimulus and observation
  localparam int WCNT = 0, WCMP = 1, CLR = 2, FRC = 3;
  logic clk = 1'h0, srst = 1'h1, ce = 1'h1, tk = 1'h0, frc = 1'h0;
  logic cw = 1'h0, mw = 1'h0, cc = 1'h0, oc = 1'h0, dir = 1'h1, pv = 1'h0;
  logic [1:0] mode = 2'h2, com = 2'h1;
  logic [7:0] cd = 8'h00, md = 8'h00;
  logic [7:0] cnt, cv, cb;
  logic cmf, ovf, wave, pin, oen, lvl;
  int failures = 0;
  int n_tests = 0;

  // the timer under test and the load on its pin
  t8w_timer dut (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_tick(tk),
    .i_waveform_mode_sel(mode), .i_compare_output_mode(com), .i_force(frc),
    .i_cnt_wr(cw), .i_cnt_wdata(cd), .i_cmp_wr(mw), .i_cmp_wdata(md),
    .i_cmf_clr(cc), .i_ovf_clr(oc), .i_dir_out(dir), .i_port_val(pv),
    .o_timer_count(cnt), .o_compare_value(cv), .o_compare_buffer(cb),
    .o_compare_match_flag(cmf), .o_overflow_flag(ovf), .o_wave_output(wave),
    .o_pin_out(pin), .o_pin_oe_n(oen));
  t8w_pin_load load (.i_pin_out(pin), .i_pin_oe_n(oen), .o_level(lvl));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // =====================================================
  // tasks
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // n back-to-back timer ticks; results are settled on return
  task automatic run(input int n);
    @(posedge clk);
    tk <= 1'h1;
    repeat (n) @(posedge clk);
    tk <= 1'h0;
    #1;
  endtask

  // one-cycle software strobe: count write, compare write, flag clear or force
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge clk);
    cd <= v;
    md <= v;
    case (k)
      WCNT: cw <= 1'h1;
      WCMP: mw <= 1'h1;
      CLR: begin
        cc <= 1'h1;
        oc <= 1'h1;
      end
      default: frc <= 1'h1;
    endcase
    @(posedge clk);
    {cw, mw, cc, oc, frc} <= 5'h00;
    #1;
  endtask

  task automatic cfg(input logic [1:0] m, input logic [1:0] c);
    @(posedge clk);
    mode <= m;
    com <= c;
    #1;
  endtask

  task automatic finish_test;
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    #500000;
    failures++;
    finish_test;
  end

  // =====================================================
  // main sequence
  initial begin
    repeat (15) @(posedge clk);
    #1;
    chk1("pin_oe_n", 1'h1, oen);
    @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    #1;
    chk8("count", 8'h00, cnt);
    // direction is output, so the enable drops one cycle after release
    chk1("pin_oe_n", 1'h0, oen);
    // clear-on-compare with toggle, top at 3
    pulse(WCMP, 8'h03);
    chk8("compare", 8'h03, cv);
    run(3);
    chk8("count", 8'h03, cnt);
    run(1);
    chk8("count", 8'h00, cnt);
    chk1("wave", 1'h1, wave);
    chk1("match_flag", 1'h0, cmf);
    run(1);
    chk1("match_flag", 1'h1, cmf);
    chk1("pin", 1'h1, lvl);
    // timer enable low freezes everything
    @(posedge clk);
    ce <= 1'h0;
    run(3);
    chk8("count", 8'h01, cnt);
    @(posedge clk);
    ce <= 1'h1;
    pulse(CLR, 8'h00);
    chk1("match_flag", 1'h0, cmf);
    // count written equal to compare: that tick may not match
    pulse(WCNT, 8'h03);
    run(1);
    chk8("count", 8'h04, cnt);
    chk1("wave", 1'h1, wave);
    // compare below count: wrap through FF before matching
    run(251);
    chk8("count", 8'hFF, cnt);
    chk1("overflow", 1'h0, ovf);
    run(1);
    chk8("count", 8'h00, cnt);
    chk1("overflow", 1'h1, ovf);
    chk1("match_flag", 1'h0, cmf);
    run(4);
    chk1("wave", 1'h0, wave);
    // direction input hides the low wave behind the pull-up
    @(posedge clk);
    dir <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk1("pin_oe_n", 1'h1, oen);
    chk1("pin", 1'h1, lvl);
    @(posedge clk);
    dir <= 1'h1;
    pulse(FRC, 8'h00);
    chk1("wave", 1'h1, wave);
    chk8("count", 8'h00, cnt);
    // fast pwm, non-inverting, buffered compare 40
    cfg(2'h3, 2'h2);
    pulse(CLR, 8'h00);
    pulse(WCMP, 8'h40);
    chk8("buffer", 8'h40, cb);
    chk8("compare", 8'h03, cv);
    pulse(WCNT, 8'hFE);
    run(1);
    chk8("count", 8'hFF, cnt);
    chk1("overflow", 1'h0, ovf);
    run(1);
    chk8("count", 8'h00, cnt);
    chk1("overflow", 1'h1, ovf);
    chk8("compare", 8'h40, cv);
    chk1("wave", 1'h1, wave);
    run(65);
    chk1("wave", 1'h0, wave);
    cfg(2'h3, 2'h3);
    run(191);
    chk8("count", 8'h00, cnt);
    chk1("wave", 1'h0, wave);
    run(65);
    chk1("wave", 1'h1, wave);
    // compare at max, inverting: match ignored, level held
    pulse(WCMP, 8'hFF);
    run(191);
    chk8("compare", 8'hFF, cv);
    chk1("wave", 1'h0, wave);
    run(255);
    chk1("wave", 1'h0, wave);
    // compare at bottom, non-inverting: one-tick spike
    cfg(2'h3, 2'h2);
    pulse(WCMP, 8'h00);
    run(1);
    chk1("wave", 1'h1, wave);
    run(1);
    chk1("wave", 1'h0, wave);
    run(254);
    chk1("wave", 1'h0, wave);
    cfg(2'h3, 2'h1);
    run(2);
    chk1("wave", 1'h1, wave);
    // phase-correct, non-inverting, compare 80 loaded at top
    cfg(2'h1, 2'h2);
    pulse(CLR, 8'h00);
    pulse(WCMP, 8'h80);
    chk8("compare", 8'h00, cv);
    pulse(WCNT, 8'hFE);
    run(1);
    chk8("count", 8'hFF, cnt);
    run(1);
    chk8("count", 8'hFE, cnt);
    chk8("compare", 8'h80, cv);
    chk1("wave", 1'h0, wave);
    chk1("overflow", 1'h0, ovf);
    run(127);
    chk1("wave", 1'h1, wave);
    run(127);
    chk8("count", 8'h00, cnt);
    chk1("overflow", 1'h0, ovf);
    run(1);
    chk8("count", 8'h01, cnt);
    chk1("overflow", 1'h1, ovf);
    run(128);
    chk1("wave", 1'h0, wave);
    // compare at max loads at this top, so the level stays low until the next top
    pulse(WCMP, 8'hFF);
    run(127);
    chk1("wave", 1'h0, wave);
    run(253);
    chk8("count", 8'h01, cnt);
    chk1("wave", 1'h0, wave);
    run(257);
    chk8("count", 8'hFE, cnt);
    chk1("wave", 1'h1, wave);
    run(255);
    chk8("count", 8'h01, cnt);
    chk1("wave", 1'h1, wave);
    finish_test;
  end
endmodule
